// ===== dbi_bypass_in.sv
// descriptor bypass input: takes user descriptors and hands them to the engine core
// How it works
// - the host-to-card consumer index is passed on untouched for status update and interrupt.
// - each bypass input has a ready output, high only while a descriptor can be taken.
// - a descriptor flagged with error is dropped without any data movement.
// - a descriptor flagged with error marks its queue as errored.
// - the 7-bit prefetch index selects an entry of the active-queue lookup table.
// - simple and cache bypass streaming descriptors share one set of input ports.
//
// Implementation choice: strobed register access.
`timescale 1ns/100ps
module dbi_bypass_in
  import dbi_pkg::*;
(
  input  wire logic              mclk_i,
  input  wire logic              rstn_i,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [31:0]       reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [31:0]       reg_rdata_o,
  output logic                   irq_o,
  // host-to-card memory-mapped bypass input
  input  wire dbi_h2c_mm_desc_t  h2c_mm_bypass_desc_i,
  input  wire logic              h2c_mm_bypass_descriptor_valid_i,
  output logic                   h2c_mm_bypass_descriptor_ready_o,
  // card-to-host streaming bypass input
  input  wire dbi_c2h_st_desc_t  c2h_stream_bypass_desc_i,
  input  wire logic              c2h_stream_bypass_descriptor_valid_i,
  output logic                   c2h_stream_bypass_descriptor_ready_o,
  // card-to-host memory-mapped bypass input
  input  wire dbi_c2h_mm_desc_t  c2h_mm_bypass_desc_i,
  input  wire logic              c2h_mm_bypass_descriptor_valid_i,
  output logic                   c2h_mm_bypass_descriptor_ready_o,
  // prefetch engine side
  input  wire logic [TAG_W-1:0]  simple_bypass_tag_i,
  input  wire logic              pfch_tbl_wr_i,
  input  wire logic              pfch_tbl_set_i,
  input  wire logic [TAG_W-1:0]  pfch_tbl_idx_i,
  input  wire logic [QID_W-1:0]  pfch_tbl_qid_i,
  // engine core side
  output dbi_h2c_mm_desc_t       h2c_core_desc_o,
  output logic                   h2c_core_valid_o,
  input  wire logic              h2c_core_take_i,
  output dbi_c2h_st_out_t        st_core_desc_o,
  output logic                   st_core_valid_o,
  input  wire logic              st_core_take_i,
  output dbi_c2h_mm_desc_t       mm_core_desc_o,
  output logic                   mm_core_valid_o,
  input  wire logic              mm_core_take_i
);

  logic [2:0]            ctrl_q, ctrl_d;
  logic [IRQ_W-1:0]      isr_q, isr_d, imr_q, imr_d;
  logic [QID_W-1:0]      qsel_q, qsel_d, qlast_q, qlast_d;
  logic [NUM_QUEUES-1:0] qerr_q, qerr_d;
  logic [31:0]           rdata_q, rdata_d;
  logic [TAG_ENTRIES-1:0] tvld_q, tvld_d;
  logic [QID_W-1:0]      tqid_q [TAG_ENTRIES];

  logic h2c_vld_q, h2c_vld_d, st_vld_q, st_vld_d, mm_vld_q, mm_vld_d;
  dbi_h2c_mm_desc_t h2c_q, h2c_d;
  dbi_c2h_st_out_t  st_q, st_d;
  dbi_c2h_mm_desc_t mm_q, mm_d;
  logic h2c_acc, st_acc, mm_acc, st_drop;

  // one-entry holding stage per port; ready falls as soon as it is occupied
  assign h2c_mm_bypass_descriptor_ready_o     = ctrl_q[CTRL_H2C_MM_EN] & ~h2c_vld_q;
  assign c2h_stream_bypass_descriptor_ready_o = ctrl_q[CTRL_C2H_ST_EN] & ~st_vld_q;
  assign c2h_mm_bypass_descriptor_ready_o     = ctrl_q[CTRL_C2H_MM_EN] & ~mm_vld_q;
  assign h2c_acc = h2c_mm_bypass_descriptor_valid_i & h2c_mm_bypass_descriptor_ready_o;
  assign st_acc  = c2h_stream_bypass_descriptor_valid_i &
                   c2h_stream_bypass_descriptor_ready_o;
  assign mm_acc  = c2h_mm_bypass_descriptor_valid_i & c2h_mm_bypass_descriptor_ready_o;
  assign st_drop = st_acc & c2h_stream_bypass_desc_i.error;

  // descriptor stages
  always_comb begin
    h2c_vld_d = h2c_vld_q & ~h2c_core_take_i;
    h2c_d     = h2c_q;
    st_vld_d  = st_vld_q & ~st_core_take_i;
    st_d      = st_q;
    mm_vld_d  = mm_vld_q & ~mm_core_take_i;
    mm_d      = mm_q;
    if (h2c_acc) begin
      h2c_vld_d = 1'b1;
      h2c_d     = h2c_mm_bypass_desc_i;
    end
    // simple and cache bypass arrive on the same port; only the tag source differs
    if (st_acc && !st_drop) begin
      st_vld_d   = 1'b1;
      st_d.addr  = c2h_stream_bypass_desc_i.addr;
      st_d.qid   = c2h_stream_bypass_desc_i.qid;
      st_d.func  = c2h_stream_bypass_desc_i.func;
      st_d.port  = c2h_stream_bypass_desc_i.port;
      st_d.pfch_tag = c2h_stream_bypass_desc_i.pfch_tag;
      st_d.tag_hit  = tvld_q[c2h_stream_bypass_desc_i.pfch_tag];
      st_d.tag_qid  = tqid_q[c2h_stream_bypass_desc_i.pfch_tag];
    end
    if (mm_acc) begin
      mm_vld_d = 1'b1;
      mm_d     = c2h_mm_bypass_desc_i;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      h2c_vld_q <= 1'b0;
      st_vld_q  <= 1'b0;
      mm_vld_q  <= 1'b0;
      h2c_q     <= '0;
      st_q      <= '0;
      mm_q      <= '0;
    end else begin
      h2c_vld_q <= h2c_vld_d;
      st_vld_q  <= st_vld_d;
      mm_vld_q  <= mm_vld_d;
      h2c_q     <= h2c_d;
      st_q      <= st_d;
      mm_q      <= mm_d;
    end
  end

  assign h2c_core_desc_o  = h2c_q;
  assign h2c_core_valid_o = h2c_vld_q;
  assign st_core_desc_o   = st_q;
  assign st_core_valid_o  = st_vld_q;
  assign mm_core_desc_o   = mm_q;
  assign mm_core_valid_o  = mm_vld_q;

  // active-queue lookup table: valid bits reset, queue numbers need none
  always_comb begin
    tvld_d = tvld_q;
    if (pfch_tbl_wr_i) begin
      tvld_d[pfch_tbl_idx_i] = pfch_tbl_set_i;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tvld_q <= '0;
    end else begin
      tvld_q <= tvld_d;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (pfch_tbl_wr_i) begin
      tqid_q[pfch_tbl_idx_i] <= pfch_tbl_qid_i;
    end
  end

  // registers, queue error state and interrupt
  always_comb begin
    ctrl_d  = ctrl_q;
    imr_d   = imr_q;
    qsel_d  = qsel_q;
    isr_d   = isr_q;
    qerr_d  = qerr_q;
    qlast_d = qlast_q;
    rdata_d = '0;
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        CTRL_OFS:     ctrl_d = reg_wdata_i[2:0];
        IRQ_MASK_OFS: imr_d  = reg_wdata_i[IRQ_W-1:0];
        IRQ_STAT_OFS: isr_d  = isr_q & ~reg_wdata_i[IRQ_W-1:0];
        QERR_SEL_OFS: qsel_d = reg_wdata_i[QID_W-1:0];
        QERR_CLR_OFS: qerr_d[reg_wdata_i[QID_W-1:0]] = 1'b0;
        default:      ctrl_d = ctrl_q;
      endcase
    end
    // hardware events come last so a same-cycle clear never loses them
    if (st_drop) begin
      qerr_d[c2h_stream_bypass_desc_i.qid] = 1'b1;
      qlast_d = c2h_stream_bypass_desc_i.qid;
      isr_d[IRQ_ERR_DROP] = 1'b1;
    end
    if (st_acc && !st_drop && !tvld_q[c2h_stream_bypass_desc_i.pfch_tag]) begin
      isr_d[IRQ_TAG_MISS] = 1'b1;
    end
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        CTRL_OFS:      rdata_d[2:0] = ctrl_q;
        IRQ_STAT_OFS:  rdata_d[IRQ_W-1:0] = isr_q;
        IRQ_MASK_OFS:  rdata_d[IRQ_W-1:0] = imr_q;
        PFCH_TAG_OFS:  rdata_d[TAG_W-1:0] = simple_bypass_tag_i;
        QERR_SEL_OFS:  rdata_d[QID_W-1:0] = qsel_q;
        QERR_STAT_OFS: begin
          rdata_d[QERR_FLAG_BIT] = qerr_q[qsel_q];
          rdata_d[QERR_LAST_LSB +: QID_W] = qlast_q;
        end
        default:       rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_q  <= CTRL_RST;
      imr_q   <= IRQ_RST;
      isr_q   <= IRQ_RST;
      qsel_q  <= '0;
      qlast_q <= '0;
      qerr_q  <= '0;
      rdata_q <= '0;
    end else begin
      ctrl_q  <= ctrl_d;
      imr_q   <= imr_d;
      isr_q   <= isr_d;
      qsel_q  <= qsel_d;
      qlast_q <= qlast_d;
      qerr_q  <= qerr_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign irq_o       = |(isr_q & imr_q);

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  a_h2c_ready_full: assert property (h2c_vld_q |-> !h2c_mm_bypass_descriptor_ready_o)
    else $error("h2c ready high while stage full");
  a_st_ready_full: assert property (st_vld_q |-> !c2h_stream_bypass_descriptor_ready_o)
    else $error("stream ready high while stage full");
  a_h2c_cidx_kept: assert property (h2c_acc |=> h2c_core_valid_o &&
      h2c_core_desc_o.cidx == $past(h2c_mm_bypass_desc_i.cidx))
    else $error("consumer index not passed on");
  a_mm_accept_xfer: assert property (mm_acc |=> mm_core_valid_o &&
      mm_core_desc_o.waddr == $past(c2h_mm_bypass_desc_i.waddr))
    else $error("mm descriptor not captured");
  a_no_take_idle: assert property (!h2c_vld_q && !h2c_acc |=> !h2c_core_valid_o)
    else $error("h2c stage filled without handshake");
  a_err_discard: assert property (st_drop |=> !st_core_valid_o)
    else $error("errored descriptor forwarded");
  a_err_queue_mark: assert property (st_drop |=>
      qerr_q[$past(c2h_stream_bypass_desc_i.qid)] && isr_q[IRQ_ERR_DROP])
    else $error("queue error not recorded");
  a_tag_lookup_hit: assert property (st_acc && !st_drop |=>
      st_core_desc_o.tag_hit == $past(tvld_q[c2h_stream_bypass_desc_i.pfch_tag]))
    else $error("prefetch lookup mismatch");
  a_st_addr_kept: assert property (st_acc && !st_drop |=>
      st_core_desc_o.addr == $past(c2h_stream_bypass_desc_i.addr))
    else $error("stream address not captured");
endmodule

// ===== dbi_pkg.sv
// package: register map, field layouts and descriptor carriers for the bypass input block
package dbi_pkg;
  localparam int unsigned ADDR_W        = 16;
  localparam int unsigned QID_W         = 11;
  localparam int unsigned NUM_QUEUES    = 2048;
  localparam int unsigned TAG_W         = 7;
  localparam int unsigned TAG_ENTRIES   = 128;
  // register offsets (byte addresses, one 32-bit word each)
  localparam logic [ADDR_W-1:0] CTRL_OFS      = 16'h1400;
  localparam logic [ADDR_W-1:0] IRQ_STAT_OFS  = 16'h1404;
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFS  = 16'h1408;
  localparam logic [ADDR_W-1:0] PFCH_TAG_OFS  = 16'h140C;
  localparam logic [ADDR_W-1:0] QERR_SEL_OFS  = 16'h1410;
  localparam logic [ADDR_W-1:0] QERR_STAT_OFS = 16'h1414;
  localparam logic [ADDR_W-1:0] QERR_CLR_OFS  = 16'h1418;
  // control bits
  localparam int unsigned CTRL_H2C_MM_EN = 0;
  localparam int unsigned CTRL_C2H_ST_EN = 1;
  localparam int unsigned CTRL_C2H_MM_EN = 2;
  localparam logic [2:0]  CTRL_RST       = 3'h7;
  // interrupt status bits
  localparam int unsigned IRQ_W          = 2;
  localparam int unsigned IRQ_ERR_DROP   = 0;
  localparam int unsigned IRQ_TAG_MISS   = 1;
  localparam logic [IRQ_W-1:0] IRQ_RST   = 2'h0;
  // queue error status layout
  localparam int unsigned QERR_FLAG_BIT  = 0;
  localparam int unsigned QERR_LAST_LSB  = 16;

  typedef struct packed {
    logic [15:0] cidx;
    logic [7:0]  func;
    logic [2:0]  port;
  } dbi_h2c_mm_desc_t;

  typedef struct packed {
    logic [63:0]      addr;
    logic [QID_W-1:0] qid;
    logic             error;
    logic [7:0]       func;
    logic [2:0]       port;
    logic [TAG_W-1:0] pfch_tag;
  } dbi_c2h_st_desc_t;

  typedef struct packed {
    logic [63:0]      addr;
    logic [QID_W-1:0] qid;
    logic [7:0]       func;
    logic [2:0]       port;
    logic [TAG_W-1:0] pfch_tag;
    logic             tag_hit;
    logic [QID_W-1:0] tag_qid;
  } dbi_c2h_st_out_t;

  typedef struct packed {
    logic [63:0] raddr;
    logic [63:0] waddr;
  } dbi_c2h_mm_desc_t;
endpackage

// ===== dbi_user_model.sv
// user-logic model handing streaming bypass descriptors back to the block
`timescale 1ns/100ps
module dbi_user_model
  import dbi_pkg::*;
(
  input  wire logic             mclk_i,
  input  wire logic             rstn_i,
  input  wire logic             send_i,
  input  wire logic [3:0]       delay_i,
  input  wire dbi_c2h_st_desc_t desc_i,
  input  wire logic             ready_i,
  output logic                  valid_o,
  output dbi_c2h_st_desc_t      desc_o,
  output logic                  busy_o
);
  logic [3:0]       wait_q;
  dbi_c2h_st_desc_t hold_q;
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      valid_o <= 1'b0;
      busy_o  <= 1'b0;
      wait_q  <= 4'h0;
      hold_q  <= '0;
      desc_o  <= '0;
    end else if (send_i && !busy_o) begin
      busy_o <= 1'b1;
      wait_q <= delay_i;
      hold_q <= desc_i;
    end else if (busy_o && !valid_o) begin
      if (wait_q == 4'h0) begin
        valid_o <= 1'b1;
        desc_o  <= hold_q;
      end else begin
        wait_q <= wait_q - 4'h1;
      end
    end else if (valid_o && ready_i) begin
      valid_o <= 1'b0;
      busy_o  <= 1'b0;
      desc_o  <= ~desc_o; // released fields must not keep the last value
    end
  end
endmodule

// ===== dbi_bypass_in_test.sv
// self-checking bench for the descriptor bypass input block
`timescale 1ns/100ps
module dbi_bypass_in_test
  import dbi_pkg::*;
;
  logic mclk_i = 0, rstn_i = 0, reg_wr_i = 0, reg_rd_i = 0, send = 0, pfch_tbl_wr_i = 0;
  logic pfch_tbl_set_i = 0, h2c_core_take_i = 0, st_core_take_i = 0, mm_core_take_i = 0;
  logic h2c_mm_bypass_descriptor_valid_i = 0, c2h_mm_bypass_descriptor_valid_i = 0;
  logic [ADDR_W-1:0] reg_addr_i = '0;
  logic [31:0]       reg_wdata_i = '0, reg_rdata_o;
  logic [TAG_W-1:0]  simple_bypass_tag_i = 7'h22, pfch_tbl_idx_i = '0;
  logic [QID_W-1:0]  pfch_tbl_qid_i = '0;
  logic [3:0]        dly = 4'h0;
  dbi_h2c_mm_desc_t  h2c_mm_bypass_desc_i = '0, h2c_core_desc_o;
  dbi_c2h_st_desc_t  c2h_stream_bypass_desc_i, st_in = '0;
  dbi_c2h_mm_desc_t  c2h_mm_bypass_desc_i = '0, mm_core_desc_o;
  dbi_c2h_st_out_t   st_core_desc_o;
  logic irq_o, h2c_core_valid_o, st_core_valid_o, mm_core_valid_o, busy;
  logic h2c_mm_bypass_descriptor_ready_o, c2h_stream_bypass_descriptor_ready_o;
  logic c2h_stream_bypass_descriptor_valid_i, c2h_mm_bypass_descriptor_ready_o;
  int num_errors = 0, checked = 0;

  always #10 mclk_i = ~mclk_i;

  dbi_bypass_in dut (.mclk_i, .rstn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .irq_o, .h2c_mm_bypass_desc_i, .h2c_mm_bypass_descriptor_valid_i,
    .h2c_mm_bypass_descriptor_ready_o, .c2h_stream_bypass_desc_i,
    .c2h_stream_bypass_descriptor_valid_i, .c2h_stream_bypass_descriptor_ready_o,
    .c2h_mm_bypass_desc_i, .c2h_mm_bypass_descriptor_valid_i, .c2h_mm_bypass_descriptor_ready_o,
    .simple_bypass_tag_i, .pfch_tbl_wr_i, .pfch_tbl_set_i, .pfch_tbl_idx_i, .pfch_tbl_qid_i,
    .h2c_core_desc_o, .h2c_core_valid_o, .h2c_core_take_i, .st_core_desc_o, .st_core_valid_o,
    .st_core_take_i, .mm_core_desc_o, .mm_core_valid_o, .mm_core_take_i);

  dbi_user_model user (.mclk_i, .rstn_i, .send_i(send), .delay_i(dly), .desc_i(st_in),
    .ready_i(c2h_stream_bypass_descriptor_ready_o), .valid_o(c2h_stream_bypass_descriptor_valid_i),
    .desc_o(c2h_stream_bypass_desc_i), .busy_o(busy));

  task automatic final_report;
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [127:0] exp, input logic [127:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i) reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] exp, input string nm);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i) reg_rd_i <= 1'b0;
    #1 chk(nm, 128'(exp), 128'(reg_rdata_o));
  endtask

  // hand one descriptor to the user model and wait until the block took it
  task automatic st_send(input dbi_c2h_st_desc_t d, input logic [3:0] w);
    int n;
    n = 0;
    @(posedge mclk_i);
    st_in <= d;
    dly <= w;
    send <= 1'b1;
    @(posedge mclk_i) send <= 1'b0;
    #1;
    while (busy && n < 40) begin
      @(posedge mclk_i);
      #1 n++;
    end
    // a descriptor that never got taken counts against the run
    if (busy) begin
      num_errors++;
      $display("FAIL st_send expected %h seen %h", 1'b0, busy);
    end
  endtask

  initial begin
    repeat (5000) @(posedge mclk_i);
    num_errors++;
    final_report();
  end

  initial begin
    repeat (3) @(posedge mclk_i);
    rstn_i <= 1'b1;
    rd(CTRL_OFS, 32'h7, "ctrl");
    rd(IRQ_MASK_OFS, 32'h0, "irq_mask");
    rd(PFCH_TAG_OFS, 32'h22, "pfch_tag");
    rd(16'h1420, 32'h0, "unmapped");
    @(posedge mclk_i);
    h2c_mm_bypass_desc_i <= '{cidx: 16'hBEEF, func: 8'h3C, port: 3'h5};
    h2c_mm_bypass_descriptor_valid_i <= 1'b1;
    @(posedge mclk_i) h2c_mm_bypass_desc_i <= '{cidx: 16'h1234, func: 8'h01, port: 3'h2};
    repeat (3) @(posedge mclk_i);
    #1 chk("h2c_core", {1'b1, 16'hBEEF, 8'h3C, 3'h5}, {h2c_core_valid_o, h2c_core_desc_o});
    chk("h2c_ready_full", 1'b0, h2c_mm_bypass_descriptor_ready_o);
    @(posedge mclk_i) h2c_core_take_i <= 1'b1;
    @(posedge mclk_i) h2c_core_take_i <= 1'b0;
    @(posedge mclk_i) h2c_mm_bypass_descriptor_valid_i <= 1'b0;
    #1 chk("h2c_held", {1'b1, 16'h1234, 8'h01, 3'h2}, {h2c_core_valid_o, h2c_core_desc_o});
    @(posedge mclk_i);
    pfch_tbl_wr_i <= 1'b1;
    pfch_tbl_set_i <= 1'b1;
    pfch_tbl_idx_i <= 7'h05;
    pfch_tbl_qid_i <= 11'h123;
    @(posedge mclk_i) pfch_tbl_wr_i <= 1'b0;
    st_send('{64'h0123_4567_89AB_CDE0, 11'h3FF, 1'b0, 8'h11, 3'h2, 7'h05}, 4'h3);
    chk("st_cache", {1'b1, 64'h0123_4567_89AB_CDE0, 11'h3FF, 8'h11, 3'h2, 7'h05, 1'b1, 11'h123},
      {st_core_valid_o, st_core_desc_o});
    @(posedge mclk_i) st_core_take_i <= 1'b1;
    @(posedge mclk_i) st_core_take_i <= 1'b0;
    st_send('{64'h0000_0000_0000_1000, 11'h001, 1'b0, 8'h02, 3'h1, 7'h22}, 4'h0);
    chk("st_simple", {1'b1, 7'h22, 1'b0}, {st_core_valid_o, st_core_desc_o.pfch_tag,
      st_core_desc_o.tag_hit});
    @(posedge mclk_i) st_core_take_i <= 1'b1;
    @(posedge mclk_i) st_core_take_i <= 1'b0;
    st_send('{64'hFFFF_0000_0000_0040, 11'h0AB, 1'b1, 8'h00, 3'h0, 7'h05}, 4'h1);
    chk("st_dropped", 1'b0, st_core_valid_o);
    rd(IRQ_STAT_OFS, 32'h3, "irq_stat");
    chk("irq_masked", 1'b0, irq_o);
    wr(IRQ_MASK_OFS, 32'h1);
    #1 chk("irq_on", 1'b1, irq_o);
    wr(QERR_SEL_OFS, 32'h0AB);
    rd(QERR_STAT_OFS, 32'h00AB_0001, "qerr_stat");
    wr(QERR_CLR_OFS, 32'h0AB);
    wr(IRQ_STAT_OFS, 32'h1);
    #1 chk("irq_off", 1'b0, irq_o);
    rd(QERR_STAT_OFS, 32'h00AB_0000, "qerr_clr");
    @(posedge mclk_i);
    c2h_mm_bypass_desc_i <= '{raddr: 64'hA5A5_0000_1111_2222, waddr: 64'h5A5A_3333_4444_5550};
    c2h_mm_bypass_descriptor_valid_i <= 1'b1;
    @(posedge mclk_i) c2h_mm_bypass_descriptor_valid_i <= 1'b0;
    #1 chk("mm_core", {64'hA5A5_0000_1111_2222, 64'h5A5A_3333_4444_5550}, mm_core_desc_o);
    wr(CTRL_OFS, 32'h0);
    #1 chk("readies_off", 3'h0, {h2c_mm_bypass_descriptor_ready_o,
      c2h_stream_bypass_descriptor_ready_o, c2h_mm_bypass_descriptor_ready_o});
    final_report();
  end
endmodule
